// ---- logic/tbc_core.sv ----
`timescale 1ns/100ps
`include "tbc_cfg.svh"
// Contract
// [R01] counter, compares, capture are 16 bits
// [R02] one shared high-byte latch per timer
// [R03] low write loads latch and byte together
// [R04] low read copies high byte to latch
// [R05] compare high reads bypass the latch
// [R06] cpu writes high first, reads low first
// [R07] cpu masks interrupts around two-byte access; tbc_cpu_model masks nothing
// [R08] prescaler or pin clocks; none means stopped
// [R09] buffered compares match continuously, set flags
// [R10] four sources, flag and mask registers
// [R11] capture edge copies counter, optional filter
// [R12] bottom is 0x0000, max is 0xffff
// [R13] top fixed 8/9/10-bit, compare a or capture
// [R14] compare a as top gives no pwm
// [R15] power-down bit set disables timer
// [R16] cpu counter write beats clear and count
// [R17] capture flag set with capture copy
// [R18] latch and 16-bit registers reset zero
module tbc_core #(
   parameter int NC_LEN = `TBC_NC_LEN
) (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire logic       clk_en,
   // register port
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   // pins
   input  wire logic       external_count_pin,
   input  wire logic       capture_pin,
   output logic            waveform_out_pin_a,
   output logic            waveform_out_pin_b,
   // interrupt
   output logic            irq
);
   import tbc_pkg::*;
   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   logic [7:0]  ctrl_a_r;          // bit2:0 top select, bit4 pwm, bit5 nc, bit6 cap edge
   logic [7:0]  ctrl_b_r;          // bit2:0 clock select
   logic        timer_power_down_bit;  // 1 stops the module
   logic [15:0] count_value;       // R01
   logic [15:0] compare_value_a;   // active compare a
   logic [15:0] compare_value_b;
   logic [15:0] cmpa_buf_r;        // cpu-side buffer of compare a
   logic [15:0] cmpb_buf_r;
   logic [15:0] capture_value;
   logic [7:0]  hi_latch_r;        // R02 shared high byte
   logic [3:0]  irq_flag_reg;
   logic [3:0]  irq_mask_reg;
   logic [7:0]  rdata_r;
   logic [1:0]  cap_sy_r;          // capture pin synchroniser
   logic [1:0]  ext_sy_r;          // count pin synchroniser
   logic [NC_LEN-1:0] nc_r;        // noise filter history
   logic        cap_f_r;           // filtered capture level
   logic        cap_d_r;           // previous level for edge detect
   // decoded strobes
   logic        run;
   logic        tick;
   logic [15:0] top_val;
   logic        at_top;
   logic        cnt_wr;
   logic        cap_evt;
   logic        cap_lvl;
   logic        pwm_mode;
   tbc_top_type top_sel;
   logic [3:0]  evt;               // events in flag layout
   tbc_tick_if  tk ();
   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   // low-byte write strobe for a given address
   function automatic logic wr_lo(input logic [7:0] a);
      wr_lo = wr && (addr == a);
   endfunction
   assign run      = !timer_power_down_bit;                       // R15
   assign top_sel  = tbc_top_type'(ctrl_a_r[2:0]);
   assign pwm_mode = ctrl_a_r[4];
   assign cnt_wr   = wr && (addr == `TBC_A_CNT_L);
   assign tk.sel   = ctrl_b_r[2:0];
   assign tk.ext_lvl = ext_sy_r[1];
   assign tick     = tk.tick;
   tbc_tick_gen u_tick (
      .ref_clk (ref_clk),
      .reset   (reset),
      .clk_en  (clk_en),
      .run     (run),
      .tk      (tk.gen)
   );
   // -----------------------------------------------------------------
   // top selection
   // -----------------------------------------------------------------
   // fixed, compare a or capture limit
   always_comb begin
      unique case (top_sel)
         TBC_TOP_8:    top_val = `TBC_TOP8;                        // R13
         TBC_TOP_9:    top_val = `TBC_TOP9;
         TBC_TOP_10:   top_val = `TBC_TOP10;
         TBC_TOP_CMPA: top_val = compare_value_a;
         TBC_TOP_CAP:  top_val = capture_value;
         default:      top_val = `TBC_MAX;                         // R12
      endcase
   end
   assign at_top = (count_value == top_val);
   // -----------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------
   // two stages before anything reads the pins
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cap_sy_r <= 2'h0;
         ext_sy_r <= 2'h0;
      end else if (clk_en) begin
         cap_sy_r <= {cap_sy_r[0], capture_pin};
         ext_sy_r <= {ext_sy_r[0], external_count_pin};
      end
   end
   // -----------------------------------------------------------------
   // capture filter and edge
   // -----------------------------------------------------------------
   // filter accepts a level only after NC_LEN equal samples;
   // trades NC_LEN+1 cycles of extra capture delay for spike rejection
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         nc_r    <= '0;
         cap_f_r <= 1'b0;
         cap_d_r <= 1'b0;
      end else if (clk_en && run) begin
         nc_r <= {nc_r[NC_LEN-2:0], cap_sy_r[1]};
         if (&nc_r)
            cap_f_r <= 1'b1;                                      // R11
         else if (~|nc_r)
            cap_f_r <= 1'b0;
         cap_d_r <= cap_lvl;
      end
   end
   assign cap_lvl = ctrl_a_r[5] ? cap_f_r : cap_sy_r[1];
   // bit6 set picks rising edge, clear picks falling
   assign cap_evt = run && (ctrl_a_r[6] ? (cap_lvl && !cap_d_r) : (!cap_lvl && cap_d_r)); // R11
   // -----------------------------------------------------------------
   // counter
   // -----------------------------------------------------------------
   // cpu write first, then wrap at top, then count
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         count_value <= `TBC_BOTTOM;                               // R18
      end else if (clk_en) begin
         if (cnt_wr)
            count_value <= {hi_latch_r, wdata};                    // R16 R03
         else if (tick && at_top)
            count_value <= `TBC_BOTTOM;                            // R12
         else if (tick)
            count_value <= count_value + 16'h0001;
      end
   end
   // -----------------------------------------------------------------
   // compare buffers
   // -----------------------------------------------------------------
   // pwm modes take the buffer at top so top changes are glitch free
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cmpa_buf_r      <= 16'h0000;                              // R18
         cmpb_buf_r      <= 16'h0000;
         compare_value_a <= 16'h0000;
         compare_value_b <= 16'h0000;
      end else if (clk_en) begin
         if (wr_lo(`TBC_A_CMPA_L))
            cmpa_buf_r <= {hi_latch_r, wdata};                     // R03
         if (wr_lo(`TBC_A_CMPB_L))
            cmpb_buf_r <= {hi_latch_r, wdata};
         if (!pwm_mode || (tick && at_top)) begin
            compare_value_a <= cmpa_buf_r;                         // R14
            compare_value_b <= cmpb_buf_r;
         end
      end
   end
   // -----------------------------------------------------------------
   // capture register
   // -----------------------------------------------------------------
   // writable only when it serves as top
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         capture_value <= 16'h0000;                                // R18
      end else if (clk_en) begin
         if (wr_lo(`TBC_A_CAP_L) && top_sel == TBC_TOP_CAP)
            capture_value <= {hi_latch_r, wdata};
         else if (cap_evt && top_sel != TBC_TOP_CAP)
            capture_value <= count_value;                          // R11
      end
   end
   // -----------------------------------------------------------------
   // shared high byte latch
   // -----------------------------------------------------------------
   // one latch for all 16-bit registers; software must not interleave
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         hi_latch_r <= `TBC_RST_BYTE;                              // R18
      end else if (clk_en) begin
         if (wr && (addr == `TBC_A_CNT_H || addr == `TBC_A_CMPA_H ||
                    addr == `TBC_A_CMPB_H || addr == `TBC_A_CAP_H))
            hi_latch_r <= wdata;                                   // R02 R06
         else if (rd && addr == `TBC_A_CNT_L)
            hi_latch_r <= count_value[15:8];                       // R04
         else if (rd && addr == `TBC_A_CAP_L)
            hi_latch_r <= capture_value[15:8];                     // R04
      end
   end
   // -----------------------------------------------------------------
   // control and power registers
   // -----------------------------------------------------------------
   // plain byte registers, no access sequence
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ctrl_a_r             <= 8'h00;
         ctrl_b_r             <= 8'h00;
         timer_power_down_bit <= 1'b0;
         irq_mask_reg         <= 4'h0;
      end else if (clk_en && wr) begin
         if (addr == `TBC_A_CTRL_A) ctrl_a_r <= wdata;             // R01
         if (addr == `TBC_A_CTRL_B) ctrl_b_r <= wdata;
         if (addr == `TBC_A_PWR)    timer_power_down_bit <= wdata[0]; // R15
         if (addr == `TBC_A_MASK)   irq_mask_reg <= wdata[3:0];    // R10
      end
   end
   // -----------------------------------------------------------------
   // flags
   // -----------------------------------------------------------------
   // overflow at max or top, compare on match at tick, capture on copy
   assign evt[`TBC_FLAG_OVF]  = tick && at_top && !cnt_wr;
   assign evt[`TBC_FLAG_CMPA] = tick && (count_value == compare_value_a); // R09
   assign evt[`TBC_FLAG_CMPB] = tick && (count_value == compare_value_b); // R09
   assign evt[`TBC_FLAG_CAP]  = cap_evt && top_sel != TBC_TOP_CAP;        // R17
   // write one clears; a new event in the same cycle wins
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         irq_flag_reg <= 4'h0;
      end else if (clk_en) begin
         irq_flag_reg <= (irq_flag_reg & ~((wr && addr == `TBC_A_FLAG) ? wdata[3:0] : 4'h0)) | evt; // R10
      end
   end
   assign irq = |(irq_flag_reg & irq_mask_reg);                   // R10
   // -----------------------------------------------------------------
   // waveform outputs
   // -----------------------------------------------------------------
   // toggle on match; compare a gives no pwm when it is the top
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         waveform_out_pin_a <= 1'b0;
         waveform_out_pin_b <= 1'b0;
      end else if (clk_en) begin
         if (evt[`TBC_FLAG_CMPA] && !(pwm_mode && top_sel == TBC_TOP_CMPA))
            waveform_out_pin_a <= !waveform_out_pin_a;             // R14 R09
         if (evt[`TBC_FLAG_CMPB])
            waveform_out_pin_b <= !waveform_out_pin_b;
      end
   end
   // -----------------------------------------------------------------
   // read port
   // -----------------------------------------------------------------
   // high reads of count and capture come from the latch
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rdata_r <= 8'h00;
      end else if (clk_en) begin
         rdata_r <= 8'h00;
         if (rd) begin
            unique case (addr)
               `TBC_A_CTRL_A: rdata_r <= ctrl_a_r;
               `TBC_A_CTRL_B: rdata_r <= ctrl_b_r;
               `TBC_A_CNT_L:  rdata_r <= count_value[7:0];
               `TBC_A_CNT_H:  rdata_r <= hi_latch_r;
               `TBC_A_CMPA_L: rdata_r <= cmpa_buf_r[7:0];
               `TBC_A_CMPA_H: rdata_r <= cmpa_buf_r[15:8];         // R05
               `TBC_A_CMPB_L: rdata_r <= cmpb_buf_r[7:0];
               `TBC_A_CMPB_H: rdata_r <= cmpb_buf_r[15:8];         // R05
               `TBC_A_CAP_L:  rdata_r <= capture_value[7:0];
               `TBC_A_CAP_H:  rdata_r <= hi_latch_r;
               `TBC_A_FLAG:   rdata_r <= {4'h0, irq_flag_reg};
               `TBC_A_MASK:   rdata_r <= {4'h0, irq_mask_reg};
               `TBC_A_PWR:    rdata_r <= {7'h00, timer_power_down_bit};
               default:       rdata_r <= 8'h00;
            endcase
         end
      end
   end
   assign rdata = rdata_r;
   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   sequence s_lo_write;
      wr && addr == `TBC_A_CNT_L;
   endsequence
   property p_cnt_load;
      @(posedge ref_clk) disable iff (reset)
      (s_lo_write and clk_en) |=> count_value == {$past(hi_latch_r), $past(wdata)};
   endproperty
   a_cnt_load: assert property (p_cnt_load) else $error("counter low write not loaded"); // R03
   property p_lo_read;
      @(posedge ref_clk) disable iff (reset)
      (clk_en && rd && addr == `TBC_A_CNT_L) |=> hi_latch_r == $past(count_value[15:8]);
   endproperty
   a_lo_read: assert property (p_lo_read) else $error("latch missed high byte"); // R04
   property p_cmp_hi;
      @(posedge ref_clk) disable iff (reset)
      (clk_en && rd && addr == `TBC_A_CMPA_H) |=> hi_latch_r == $past(hi_latch_r) && rdata == $past(cmpa_buf_r[15:8]);
   endproperty
   a_cmp_hi: assert property (p_cmp_hi) else $error("compare high read wrong"); // R05
   property p_stopped;
      @(posedge ref_clk) disable iff (reset)
      (clk_en && ctrl_b_r[2:0] == 3'h0 && !cnt_wr) |=> $stable(count_value);
   endproperty
   a_stopped: assert property (p_stopped) else $error("counter moved without clock"); // R08
   property p_cmp_flag;
      @(posedge ref_clk) disable iff (reset)
      (clk_en && evt[`TBC_FLAG_CMPA]) |=> irq_flag_reg[`TBC_FLAG_CMPA];
   endproperty
   a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag not set"); // R09
   property p_irq;
      @(posedge ref_clk) disable iff (reset)
      (clk_en && |(evt & irq_mask_reg) && !(wr && addr == `TBC_A_MASK)) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq not masked flags"); // R10
   property p_cap;
      @(posedge ref_clk) disable iff (reset)
      (clk_en && evt[`TBC_FLAG_CAP] && !wr) |=> capture_value == $past(count_value) && irq_flag_reg[`TBC_FLAG_CAP];
   endproperty
   a_cap: assert property (p_cap) else $error("capture copy or flag missing"); // R17
   property p_wrap;
      @(posedge ref_clk) disable iff (reset)
      (clk_en && tick && at_top && !cnt_wr) |=> count_value == `TBC_BOTTOM;
   endproperty
   a_wrap: assert property (p_wrap) else $error("counter did not wrap at top"); // R13
   property p_pwr;
      @(posedge ref_clk) disable iff (reset)
      timer_power_down_bit |-> !tick;
   endproperty
   a_pwr: assert property (p_pwr) else $error("tick while powered down"); // R15
endmodule

// ---- logic/tbc_cfg.svh ----
`ifndef TBC_CFG_SVH
`define TBC_CFG_SVH
// -----------------------------------------------------------------
// register map (byte addresses on the 8-bit port)
// -----------------------------------------------------------------
`define TBC_A_CTRL_A      8'h00
`define TBC_A_CTRL_B      8'h01
`define TBC_A_CNT_L       8'h02
`define TBC_A_CNT_H       8'h03
`define TBC_A_CMPA_L      8'h04
`define TBC_A_CMPA_H      8'h05
`define TBC_A_CMPB_L      8'h06
`define TBC_A_CMPB_H      8'h07
`define TBC_A_CAP_L       8'h08
`define TBC_A_CAP_H       8'h09
`define TBC_A_FLAG        8'h0a
`define TBC_A_MASK        8'h0b
`define TBC_A_PWR         8'h0c
// -----------------------------------------------------------------
// fields and constants
// -----------------------------------------------------------------
`define TBC_FLAG_OVF      0
`define TBC_FLAG_CMPA     1
`define TBC_FLAG_CMPB     2
`define TBC_FLAG_CAP      3
`define TBC_BOTTOM        16'h0000
`define TBC_MAX           16'hffff
`define TBC_TOP8          16'h00ff
`define TBC_TOP9          16'h01ff
`define TBC_TOP10         16'h03ff
`define TBC_NC_LEN        4
`define TBC_RST_BYTE      8'h00
`endif

// ---- logic/tbc_pkg.sv ----
package tbc_pkg;
   // top source selection, control register a bits 2:0
   typedef enum logic [2:0] {
      TBC_TOP_MAX  = 3'h0,
      TBC_TOP_8    = 3'h1,
      TBC_TOP_9    = 3'h2,
      TBC_TOP_10   = 3'h3,
      TBC_TOP_CMPA = 3'h4,
      TBC_TOP_CAP  = 3'h5
   } tbc_top_type;
   // clock select, control register b bits 2:0
   typedef enum logic [2:0] {
      TBC_CS_OFF  = 3'h0,
      TBC_CS_D1   = 3'h1,
      TBC_CS_D8   = 3'h2,
      TBC_CS_D64  = 3'h3,
      TBC_CS_D256 = 3'h4,
      TBC_CS_D1K  = 3'h5,
      TBC_CS_EXTF = 3'h6,
      TBC_CS_EXTR = 3'h7
   } tbc_cs_type;
endpackage

// ---- logic/tbc_tick_if.sv ----
`timescale 1ns/100ps
// tick source control and result between top and tick generator
interface tbc_tick_if;
   logic [2:0] sel;      // clock select code
   logic       ext_lvl;  // synchronised external count level
   logic       tick;     // one-cycle timer tick
   modport gen (input sel, input ext_lvl, output tick);
   modport use_ (output sel, output ext_lvl, input tick);
endinterface

// ---- logic/tbc_tick_gen.sv ----
`timescale 1ns/100ps
`include "tbc_cfg.svh"
// prescaler and external edge select producing the timer tick
module tbc_tick_gen (
   // clock and control
   input  wire logic ref_clk,
   input  wire logic reset,
   input  wire logic clk_en,
   input  wire logic run,
   // tick link
   tbc_tick_if.gen   tk
);
   import tbc_pkg::*;
   // -----------------------------------------------------------------
   // prescaler
   // -----------------------------------------------------------------
   logic [9:0] pre_r;    // free prescaler count
   logic       ext_d_r;  // previous external level
   // prescaler restarts while powered down (run low) so first tick is a full period
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pre_r   <= 10'h000;
         ext_d_r <= 1'b0;
      end else if (clk_en) begin
         pre_r   <= run ? pre_r + 10'h001 : 10'h000;
         ext_d_r <= tk.ext_lvl;
      end
   end
   // tick select; stopped when no source chosen
   always_comb begin
      unique case (tbc_cs_type'(tk.sel))
         TBC_CS_OFF:  tk.tick = 1'b0;                            // R08
         TBC_CS_D1:   tk.tick = run;
         TBC_CS_D8:   tk.tick = run && (pre_r[2:0] == 3'h7);
         TBC_CS_D64:  tk.tick = run && (pre_r[5:0] == 6'h3f);
         TBC_CS_D256: tk.tick = run && (pre_r[7:0] == 8'hff);
         TBC_CS_D1K:  tk.tick = run && (pre_r == 10'h3ff);
         TBC_CS_EXTF: tk.tick = run && ext_d_r && !tk.ext_lvl;   // R08
         TBC_CS_EXTR: tk.tick = run && !ext_d_r && tk.ext_lvl;
      endcase
   end
endmodule

// ---- tb/tbc_cpu_model.sv ----
`timescale 1ns/100ps
// -----------------------------------------------------------------
// cpu side of the byte port
// -----------------------------------------------------------------
module tbc_cpu_model (
   // clock
   input  wire logic       ref_clk,
   // register port
   output logic      [7:0] addr,
   output logic      [7:0] wdata,
   output logic            wr,
   output logic            rd,
   input  wire logic [7:0] rdata
);
   // idle bus at time zero
   initial begin
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
   end
   // one write strobe; data inverted after release so stale bytes never look valid
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
      wdata <= ~d;
   endtask
   // one read strobe, data taken in the following cycle only
   task automatic rd8(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   // high byte first; one process so nothing slips between the halves
   task automatic wr16(input logic [7:0] a, input logic [15:0] v);
      wr8(a + 8'h01, v[15:8]);
      wr8(a, v[7:0]);
   endtask
   // low byte first so the latch holds the matching high byte
   task automatic rd16(input logic [7:0] a, output logic [15:0] v);
      rd8(a, v[7:0]);
      rd8(a + 8'h01, v[15:8]);
   endtask
endmodule

// ---- tb/timer16_byte_access_core_tb.sv ----
`timescale 1ns/100ps
`include "tbc_cfg.svh"
// -----------------------------------------------------------------
// self-checking bench for the byte-access timer core
// -----------------------------------------------------------------
module timer16_byte_access_core_tb;
   import tbc_pkg::*;
   logic        ref_clk;      // 125 MHz
   logic        reset;        // async, active high
   logic [7:0]  addr;         // byte address
   logic [7:0]  wdata;        // write byte
   logic        wr;           // write strobe
   logic        rd;           // read strobe
   logic [7:0]  rdata;        // read byte
   logic        cap_pin;      // capture input
   logic        wave_a;       // compare a output
   logic        wave_b;       // compare b output
   logic        irq;          // interrupt level
   logic        ext_pin;      // count pin
   int          n_mismatch;   // failures
   int          n_checks;     // comparisons
   int          cyc;          // timeout counter
   logic [7:0]  seed;         // lfsr state
   logic [15:0] v;            // readback
   logic [7:0]  b;            // byte readback
   logic [15:0] m_top [4];    // model of fixed top values per mode
   // clock
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // design and its cpu partner
   tbc_core #(.NC_LEN(2)) dut (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .external_count_pin(ext_pin), .capture_pin(cap_pin),
      .waveform_out_pin_a(wave_a), .waveform_out_pin_b(wave_b), .irq(irq));
   tbc_cpu_model cpu (.ref_clk(ref_clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   // 8-bit lfsr for random compare values
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // single comparison point
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // verdict
   task automatic wrap_up();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // hang guard, generous against the roughly 800 cycles used
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   // main sequence
   initial begin
      n_mismatch = 0;
      n_checks = 0;
      cyc = 0;
      seed = 8'h57;
      cap_pin = 1'b0;
      ext_pin = 1'b0;
      reset = 1'b1;
      m_top = '{16'hffff, 16'h00ff, 16'h01ff, 16'h03ff};
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      // all 16-bit registers zero out of reset
      for (int i = 0; i < 4; i++) begin
         cpu.rd16(8'h02 + 8'(2 * i), v);
         chk("reset value", v, 16'h0000);
      end
      // stopped counter keeps a full 16-bit write
      cpu.wr16(`TBC_A_CNT_L, 16'h1234);
      repeat (20) @(posedge ref_clk);
      cpu.rd16(`TBC_A_CNT_L, v);
      chk("stopped count", v, 16'h1234);
      // one shared latch: counter high byte lands in compare b
      cpu.wr8(`TBC_A_CNT_H, 8'haa);
      cpu.wr8(`TBC_A_CMPB_L, 8'hbb);
      cpu.rd8(`TBC_A_CNT_L, b);
      chk("count low", {8'h00, b}, 16'h0034);
      cpu.rd8(`TBC_A_CMPB_H, b);
      chk("compare b high", {8'h00, b}, 16'h00aa);
      cpu.rd8(`TBC_A_CNT_H, b);
      chk("latch after compare read", {8'h00, b}, 16'h0012);
      // compare a match and overflow at fixed 0xff top
      seed = lfsr(seed);
      cpu.wr16(`TBC_A_CNT_L, 16'h0000);
      cpu.wr16(`TBC_A_CMPA_L, {8'h00, seed | 8'h10});
      cpu.wr8(`TBC_A_FLAG, 8'h0f);
      cpu.wr8(`TBC_A_CTRL_A, 8'h01);
      cpu.wr8(`TBC_A_CTRL_B, 8'h01);
      repeat (300) @(posedge ref_clk);
      cpu.wr8(`TBC_A_CTRL_B, 8'h00);
      cpu.rd8(`TBC_A_FLAG, b);
      chk("match flags", {8'h00, b}, 16'h0003);
      // one toggle per match; a low value matches again after the wrap
      chk("wave a", {15'h0, wave_a}, {15'h0, (seed | 8'h10) > 8'h2d});
      chk("wave b", {15'h0, wave_b}, 16'h0000);
      cpu.wr8(`TBC_A_MASK, 8'h02);
      @(posedge ref_clk);
      chk("irq unmasked", {15'h0, irq}, 16'h0001);
      cpu.wr8(`TBC_A_FLAG, 8'h02);
      @(posedge ref_clk);
      chk("irq cleared", {15'h0, irq}, 16'h0000);
      cpu.rd8(`TBC_A_FLAG, b);
      chk("overflow flag kept", {8'h00, b}, 16'h0001);
      // wrap at each fixed top and at max
      for (int m = 0; m < 4; m++) begin
         cpu.wr16(`TBC_A_CNT_L, m_top[m] - 16'h0001);
         cpu.wr8(`TBC_A_CTRL_A, 8'(m));
         cpu.wr8(`TBC_A_FLAG, 8'h0f);
         cpu.wr8(`TBC_A_CTRL_B, 8'h01);
         repeat (10) @(posedge ref_clk);
         cpu.wr8(`TBC_A_CTRL_B, 8'h00);
         cpu.rd16(`TBC_A_CNT_L, v);
         chk("wrapped to bottom", v, 16'h000a);
         cpu.rd8(`TBC_A_FLAG, b);
         chk("overflow at top", {15'h0, b[0]}, 16'h0001);
      end
      // write while running wins over counting
      cpu.wr8(`TBC_A_CTRL_B, 8'h01);
      cpu.wr16(`TBC_A_CNT_L, 16'h0100);
      cpu.rd16(`TBC_A_CNT_L, v);
      chk("write priority", v, 16'h0101);
      cpu.wr8(`TBC_A_CTRL_B, 8'h00);
      // power-down freezes the counter
      cpu.wr16(`TBC_A_CNT_L, 16'h0050);
      cpu.wr8(`TBC_A_PWR, 8'h01);
      cpu.wr8(`TBC_A_CTRL_B, 8'h01);
      repeat (20) @(posedge ref_clk);
      cpu.wr8(`TBC_A_CTRL_B, 8'h00);
      cpu.wr8(`TBC_A_PWR, 8'h00);
      cpu.rd16(`TBC_A_CNT_L, v);
      chk("powered down count", v, 16'h0050);
      // count pin: six rises and five falls per mode
      for (int c = 6; c < 8; c++) begin
         cpu.wr16(`TBC_A_CNT_L, 16'h0000);
         cpu.wr8(`TBC_A_CTRL_B, 8'(c));
         for (int p = 0; p < 11; p++) begin
            ext_pin <= !p[0];
            repeat (4) @(posedge ref_clk);
         end
         cpu.wr8(`TBC_A_CTRL_B, 8'h00);
         ext_pin <= 1'b0;
         cpu.rd16(`TBC_A_CNT_L, v);
         chk("pin count", v, (c == 7) ? 16'h0006 : 16'h0005);
      end
      // divide by eight over 66 enabled cycles gives eight or nine ticks
      cpu.wr16(`TBC_A_CNT_L, 16'h0000);
      cpu.wr8(`TBC_A_CTRL_B, 8'h02);
      repeat (64) @(posedge ref_clk);
      cpu.wr8(`TBC_A_CTRL_B, 8'h00);
      cpu.rd16(`TBC_A_CNT_L, v);
      chk("prescaled count", {15'h0, v == 16'h0008 || v == 16'h0009}, 16'h0001);
      cpu.wr8(`TBC_A_MASK, 8'h0f);
      // rising capture edge copies the stopped counter and sets its flag
      cpu.wr8(`TBC_A_CTRL_A, 8'h40);
      cpu.wr16(`TBC_A_CNT_L, 16'h1234);
      cpu.wr8(`TBC_A_FLAG, 8'h0f);
      cap_pin <= 1'b1;
      repeat (12) @(posedge ref_clk);
      cpu.rd16(`TBC_A_CAP_L, v);
      chk("capture value", v, 16'h1234);
      cpu.rd8(`TBC_A_FLAG, b);
      chk("capture flag", {8'h00, b}, 16'h0008);
      chk("capture irq", {15'h0, irq}, 16'h0001);
      // filtered falling edge: one-cycle spike dropped, steady low taken
      cpu.wr8(`TBC_A_CTRL_A, 8'h20);
      cpu.wr16(`TBC_A_CNT_L, 16'h0777);
      cpu.wr8(`TBC_A_FLAG, 8'h0f);
      cap_pin <= 1'b0;
      @(posedge ref_clk);
      cap_pin <= 1'b1;
      repeat (9) @(posedge ref_clk);
      chk("spike irq", {15'h0, irq}, 16'h0000);
      cap_pin <= 1'b0;
      repeat (9) @(posedge ref_clk);
      cpu.rd16(`TBC_A_CAP_L, v);
      chk("filtered capture", v, 16'h0777);
      wrap_up();
   end
endmodule
